// ### src/vic_pkg.sv
// vic_pkg: constants, states and carrier types of the vectored interrupt logic
// assumes a 32-bit classic wishbone register bus and an 8-bit program memory port
package vic_pkg;
  localparam int unsigned NUM_LINES = 6;
  localparam logic [7:0]  IDX_PRIO  = 8'hF9;
  localparam logic [7:0]  IDX_REQ   = 8'hFA;
  localparam logic [7:0]  IDX_MASK  = 8'hFB;
  localparam logic [7:0]  IDX_CTRL  = 8'hFC;
  localparam logic [7:0]  IDX_PINS  = 8'hFD;
  localparam int unsigned EDGE_HI   = 7;
  localparam int unsigned EDGE_LO   = 6;
  localparam int unsigned CTRL_GIE  = 0;
  localparam logic [2:0]  LINE_MAX  = 3'h5;
  localparam logic [1:0]  EDGE_RST  = 2'h0;
  localparam logic [5:0]  MASK_RST  = 6'h00;
  localparam logic [2:0]  PRIO_RST  = 3'h0;
  localparam logic [15:0] PM_VEC_BASE = 16'h0000;

  typedef enum logic [4:0] {
    ST_IDLE     = 5'h01,
    ST_SAVE     = 5'h02,
    ST_FETCH_HI = 5'h04,
    ST_FETCH_LO = 5'h08,
    ST_BRANCH   = 5'h10
  } vic_state_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0]  flags;
  } vic_ctx_t;

  typedef struct packed {
    logic [11:0] adr;
    logic [31:0] dat;
    logic [3:0]  sel;
    logic        we;
  } vic_wb_req_t;
endpackage

// ### src/vic_edge_detect.sv
// vic_edge_detect: one-clock edge pulse on a synchronous level, per-direction enables
// assumes the level is already synchronous to clk_i
`timescale 1ns/1ps
`default_nettype none
module vic_edge_detect (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // level and edge selection
  input  wire logic level_i,
  input  wire logic rise_en_i,
  input  wire logic fall_en_i,
  // result
  output logic      edge_o
);
  logic prev_q, prev_d;
  logic armed_q, armed_d;

  // first sample after reset only arms, so reset release never looks like an edge
  always_comb begin
    prev_d  = level_i;
    armed_d = 1'b1;
    edge_o  = armed_q & ((rise_en_i & level_i & ~prev_q) | (fall_en_i & ~level_i & prev_q));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_q  <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      prev_q  <= prev_d;
      armed_q <= armed_d;
    end
  end
endmodule
`default_nettype wire

// ### src/vic_prio_encoder.sv
// vic_prio_encoder: rotating priority pick among the request lines
// assumes top_i selects the highest line; the others follow in ascending order, wrapping
`timescale 1ns/1ps
`default_nettype none
module vic_prio_encoder (
  // requests
  input  wire logic [5:0] pending_i,
  input  wire logic [2:0] top_i,
  // choice
  output logic            valid_o,
  output logic [2:0]      index_o
);
  function automatic logic [2:0] wrap_line(input logic [3:0] v);
    wrap_line = (v > {1'b0, vic_pkg::LINE_MAX}) ? 3'(v - 4'h6) : v[2:0];
  endfunction

  always_comb begin
    logic [2:0] start;
    logic [2:0] cand;
    start   = (top_i > vic_pkg::LINE_MAX) ? 3'h0 : top_i;
    cand    = 3'h0;
    valid_o = 1'b0;
    index_o = 3'h0;
    // scan from lowest rank upward so the last hit kept is the highest ranked
    for (int k = vic_pkg::NUM_LINES - 1; k >= 0; k--) begin
      cand = wrap_line({1'b0, start} + 4'(k));
      if (pending_i[cand]) begin
        valid_o = 1'b1;
        index_o = cand;
      end
    end
  end
endmodule
`default_nettype wire

// ### src/vic_top.sv
// vic_top: vectored interrupt logic with edge selection, priority, mask and vector fetch
// assumes a classic wishbone master, a core that tells when it can be interrupted,
// and a program memory that answers a held read with a one-cycle valid
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module vic_top (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [11:0]       wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  // pins and internal event sources
  input  wire logic              port3_bit1_pin_i,
  input  wire logic              port3_bit2_pin_i,
  input  wire logic              port3_bit3_pin_i,
  input  wire logic              comparator_input_one_i,
  input  wire logic              comparator_input_two_i,
  input  wire logic              timer16_evt_i,
  input  wire logic              timer8_evt_i,
  input  wire logic              lowvolt_evt_i,
  // core sequencer
  input  wire logic              core_ready_i,
  input  wire vic_pkg::vic_ctx_t core_ctx_i,
  output vic_pkg::vic_ctx_t      save_ctx_o,
  output logic                   save_stb_o,
  output logic [15:0]            branch_addr_o,
  output logic                   branch_stb_o,
  output logic                   int_busy_o,
  // program memory read port
  output logic [15:0]            pm_addr_o,
  output logic                   pm_rd_o,
  input  wire logic [7:0]        pm_data_i,
  input  wire logic              pm_valid_i,
  // interrupt to software
  output logic                   irq_o
);
  function automatic logic [7:0] reg_index(input logic [11:0] adr);
    reg_index = adr[9:2];
  endfunction

  function automatic logic addr_ok(input logic [11:0] adr);
    addr_ok = (adr[11:10] == 2'h0) && (adr[1:0] == 2'h0);
  endfunction

  // bus request carried as one bundle
  vic_pkg::vic_wb_req_t req;
  assign req = '{adr: wb_adr_i, dat: wb_dat_i, sel: wb_sel_i, we: wb_we_i};

  logic       bus_go;
  logic       wr_lo;
  logic [7:0] idx;
  assign bus_go = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // a write lands at the edge where the master samples ack, where the transfer completes
  assign wr_lo  = wb_cyc_i & wb_stb_i & wb_ack_o & req.we & req.sel[0] & addr_ok(req.adr);
  assign idx    = reg_index(req.adr);

  // edge detection
  logic [1:0] edge_q, edge_d;
  logic       l2_rise, l2_fall, l0_rise, l0_fall;
  logic       det2, det0, det1;
  always_comb begin
    l2_rise = edge_q[1];
    l2_fall = ~edge_q[1] | edge_q[0];
    l0_rise = edge_q[0];
    l0_fall = ~edge_q[0] | edge_q[1];
  end

  vic_edge_detect u_edge2 (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .level_i   (port3_bit1_pin_i),
    .rise_en_i (l2_rise),
    .fall_en_i (l2_fall),
    .edge_o    (det2)
  );

  vic_edge_detect u_edge0 (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .level_i   (port3_bit2_pin_i),
    .rise_en_i (l0_rise),
    .fall_en_i (l0_fall),
    .edge_o    (det0)
  );

  vic_edge_detect u_edge1 (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .level_i   (port3_bit3_pin_i),
    .rise_en_i (1'b0),
    .fall_en_i (1'b1),
    .edge_o    (det1)
  );

  logic [5:0] src_evt;
  always_comb begin
    src_evt    = 6'h00;
    src_evt[0] = det0 | comparator_input_two_i;
    src_evt[1] = det1;
    src_evt[2] = det2 | comparator_input_one_i;
    src_evt[3] = timer16_evt_i;
    src_evt[4] = timer8_evt_i;
    src_evt[5] = lowvolt_evt_i;
  end

  // software registers and pending state
  logic [5:0] pend_q, pend_d;
  logic [5:0] mask_q, mask_d;
  logic [2:0] prio_q, prio_d;
  logic       gie_q, gie_d;
  logic [2:0] pins_q, pins_d;
  logic       irq_d;
  logic       ack_d;
  logic [31:0] rdat_d;

  // controller state
  vic_pkg::vic_state_t st_q, st_d;
  logic [2:0]  line_q, line_d;
  vic_pkg::vic_ctx_t ctx_q, ctx_d;
  logic        save_d;
  logic [15:0] pma_q, pma_d;
  logic        pmrd_q, pmrd_d;
  logic [7:0]  vhi_q, vhi_d;
  logic [15:0] vec_q, vec_d;
  logic        br_q, br_d;

  // masked lines never reach the encoder, but stay pending for polling
  logic       win_valid;
  logic [2:0] win_line;
  logic       grant;
  vic_prio_encoder u_prio (
    .pending_i (pend_q & mask_q),
    .top_i     (prio_q),
    .valid_o   (win_valid),
    .index_o   (win_line)
  );
  assign grant = (st_q == vic_pkg::ST_IDLE) & gie_q & core_ready_i & win_valid;

  always_comb begin
    logic [5:0] clr;
    clr    = 6'h00;
    edge_d = edge_q;
    mask_d = mask_q;
    prio_d = prio_q;
    gie_d  = gie_q;
    pins_d = {port3_bit3_pin_i, port3_bit2_pin_i, port3_bit1_pin_i};
    if (wr_lo) begin
      unique case (idx)
        vic_pkg::IDX_REQ: begin
          edge_d = req.dat[vic_pkg::EDGE_HI:vic_pkg::EDGE_LO];
          clr    = req.dat[5:0];
        end
        vic_pkg::IDX_MASK: mask_d = req.dat[5:0];
        vic_pkg::IDX_PRIO: prio_d = req.dat[2:0];
        vic_pkg::IDX_CTRL: gie_d  = req.dat[vic_pkg::CTRL_GIE];
        default: ;
      endcase
    end
    if (grant) begin
      gie_d = 1'b0;
      clr   = clr | (6'h01 << win_line);
    end
    // a new edge in the clearing cycle is kept: set wins
    pend_d = (pend_q & ~clr) | src_evt;
    irq_d  = |(pend_d & mask_d);
  end

  always_comb begin
    ack_d  = bus_go;
    rdat_d = 32'h0000_0000;
    if (bus_go && !req.we && addr_ok(req.adr)) begin
      unique case (idx)
        vic_pkg::IDX_REQ:  rdat_d = {24'h000000, edge_q, pend_q};
        vic_pkg::IDX_MASK: rdat_d = {26'h0, mask_q};
        vic_pkg::IDX_PRIO: rdat_d = {29'h0, prio_q};
        vic_pkg::IDX_CTRL: rdat_d = {31'h0, gie_q};
        vic_pkg::IDX_PINS: rdat_d = {29'h0, pins_q};
        default:           rdat_d = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    st_d   = st_q;
    line_d = line_q;
    ctx_d  = ctx_q;
    save_d = 1'b0;
    pma_d  = pma_q;
    pmrd_d = pmrd_q;
    vhi_d  = vhi_q;
    vec_d  = vec_q;
    br_d   = 1'b0;
    unique case (st_q)
      vic_pkg::ST_IDLE: begin
        if (grant) begin
          line_d = win_line;
          ctx_d  = core_ctx_i;
          st_d   = vic_pkg::ST_SAVE;
        end
      end
      vic_pkg::ST_SAVE: begin
        save_d = 1'b1;
        pma_d  = vic_pkg::PM_VEC_BASE + {12'h000, line_q, 1'b0};
        pmrd_d = 1'b1;
        st_d   = vic_pkg::ST_FETCH_HI;
      end
      vic_pkg::ST_FETCH_HI: begin
        if (pm_valid_i) begin
          vhi_d = pm_data_i;
          pma_d = pma_q + 16'h0001;
          st_d  = vic_pkg::ST_FETCH_LO;
        end
      end
      vic_pkg::ST_FETCH_LO: begin
        if (pm_valid_i) begin
          vec_d  = {vhi_q, pm_data_i};
          pmrd_d = 1'b0;
          st_d   = vic_pkg::ST_BRANCH;
        end
      end
      vic_pkg::ST_BRANCH: begin
        br_d = 1'b1;
        st_d = vic_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      edge_q   <= vic_pkg::EDGE_RST;
      pend_q   <= 6'h00;
      mask_q   <= vic_pkg::MASK_RST;
      prio_q   <= vic_pkg::PRIO_RST;
      gie_q    <= 1'b0;
      pins_q   <= 3'h0;
      irq_o    <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      edge_q   <= edge_d;
      pend_q   <= pend_d;
      mask_q   <= mask_d;
      prio_q   <= prio_d;
      gie_q    <= gie_d;
      pins_q   <= pins_d;
      irq_o    <= irq_d;
      wb_ack_o <= ack_d;
      wb_dat_o <= rdat_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q   <= vic_pkg::ST_IDLE;
      line_q <= 3'h0;
      ctx_q  <= '0;
      save_stb_o <= 1'b0;
      pma_q  <= 16'h0000;
      pmrd_q <= 1'b0;
      vhi_q  <= 8'h00;
      vec_q  <= 16'h0000;
      br_q   <= 1'b0;
      int_busy_o <= 1'b0;
    end else begin
      st_q   <= st_d;
      line_q <= line_d;
      ctx_q  <= ctx_d;
      save_stb_o <= save_d;
      pma_q  <= pma_d;
      pmrd_q <= pmrd_d;
      vhi_q  <= vhi_d;
      vec_q  <= vec_d;
      br_q   <= br_d;
      int_busy_o <= (st_d != vic_pkg::ST_IDLE);
    end
  end

  assign save_ctx_o    = ctx_q;
  assign pm_addr_o     = pma_q;
  assign pm_rd_o       = pmrd_q;
  assign branch_addr_o = vec_q;
  assign branch_stb_o  = br_q;
endmodule
`default_nettype wire

// ### testbench/vic_props.sv
// vic_props: port checks of the bus answer and the interrupt cycle
// assumes it is bound into vic_top
`timescale 1ns/1ps
`default_nettype none
module vic_props (
  // clock and reset
  input wire logic              clk_i,
  input wire logic              rst_i,
  // watched ports
  input wire logic              wb_ack_o,
  input wire logic              core_ready_i,
  input wire vic_pkg::vic_ctx_t core_ctx_i,
  input wire vic_pkg::vic_ctx_t save_ctx_o,
  input wire logic              save_stb_o,
  input wire logic [15:0]       branch_addr_o,
  input wire logic              branch_stb_o,
  input wire logic              int_busy_o,
  input wire logic [15:0]       pm_addr_o,
  input wire logic              pm_rd_o,
  input wire logic [7:0]        pm_data_i,
  input wire logic              pm_valid_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic              take;
  logic [7:0]        hi_q;
  logic [7:0]        lo_q;
  vic_pkg::vic_ctx_t ctx_q;
  assign take = pm_rd_o && pm_valid_i;
  // context frozen once busy, so it is the one seen at the grant edge
  always_ff @(posedge clk_i) begin
    if (!int_busy_o) ctx_q <= core_ctx_i;
    if (take && !pm_addr_o[0]) hi_q <= pm_data_i;
    if (take && pm_addr_o[0]) lo_q <= pm_data_i;
  end
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_grant_when_ready: assert property ($rose(int_busy_o) |-> $past(core_ready_i))
    else $error("grant without core ready");
  a_save_follows: assert property ($rose(int_busy_o) |-> ##[1:2] save_stb_o)
    else $error("no save after grant");
  a_save_ctx: assert property (save_stb_o |-> save_ctx_o == ctx_q)
    else $error("saved context wrong");
  a_vector_even: assert property (save_stb_o |-> pm_rd_o && !pm_addr_o[0]
    && pm_addr_o <= 16'h000A)
    else $error("vector fetch address wrong");
  a_read_held: assert property (pm_rd_o && !pm_valid_i |=> pm_rd_o && $stable(pm_addr_o))
    else $error("read dropped early");
  a_next_byte: assert property (take && !pm_addr_o[0] |=>
    pm_addr_o == $past(pm_addr_o) + 16'h0001)
    else $error("second vector byte not next");
  a_branch_addr: assert property (branch_stb_o |-> branch_addr_o == {hi_q, lo_q})
    else $error("handler address wrong");
  a_cycle_bound: assert property ($rose(int_busy_o) |-> ##[3:200] branch_stb_o)
    else $error("no branch after grant");
  a_busy_ends: assert property (branch_stb_o |=> !int_busy_o)
    else $error("busy after branch");
  c_save: cover property (save_stb_o);
  c_branch: cover property (branch_stb_o);
  c_slow: cover property (pm_rd_o && !pm_valid_i ##1 take);
endmodule
bind vic_top vic_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_ack_o(wb_ack_o),
  .core_ready_i(core_ready_i), .core_ctx_i(core_ctx_i), .save_ctx_o(save_ctx_o),
  .save_stb_o(save_stb_o), .branch_addr_o(branch_addr_o), .branch_stb_o(branch_stb_o),
  .int_busy_o(int_busy_o), .pm_addr_o(pm_addr_o), .pm_rd_o(pm_rd_o),
  .pm_data_i(pm_data_i), .pm_valid_i(pm_valid_i));
`default_nettype wire

// ### testbench/vic_far_model.sv
// vic_far_model: core sequencer and program memory facing vic_top
// assumes one clock; memory byte at address a is 8'h30 + a
`timescale 1ns/1ps
`default_nettype none
module vic_far_model (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // core side
  input  wire logic              busy_i,
  output vic_pkg::vic_ctx_t      ctx_o,
  output logic                   ready_o,
  // memory side
  input  wire logic [15:0]       pm_addr_i,
  input  wire logic              pm_rd_i,
  output logic [7:0]             pm_data_o,
  output logic                   pm_valid_o
);
  logic [1:0] wait_q;
  logic       slow_q;
  // answers alternate prompt and slow; idle data toggles so stale bytes show
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctx_o <= vic_pkg::vic_ctx_t'(24'h123456);
      ready_o <= 1'b0;
      pm_valid_o <= 1'b0;
      pm_data_o <= 8'h00;
      wait_q <= 2'h0;
      slow_q <= 1'b0;
    end else begin
      ctx_o <= vic_pkg::vic_ctx_t'(ctx_o + 24'h010203);
      ready_o <= !busy_i;
      if (pm_rd_i && !pm_valid_o && wait_q == {slow_q, 1'b0}) begin
        pm_valid_o <= 1'b1;
        pm_data_o <= 8'h30 + pm_addr_i[7:0];
        wait_q <= 2'h0;
        slow_q <= !slow_q;
      end else begin
        pm_valid_o <= 1'b0;
        pm_data_o <= ~pm_data_o;
        if (pm_rd_i) wait_q <= wait_q + 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
// tb_top: register, edge, polling and interrupt-cycle scenarios for vic_top
// assumes vic_props is bound in and vic_far_model plays core and memory
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [11:0] A_REQ  = {2'h0, vic_pkg::IDX_REQ, 2'h0};
  localparam logic [11:0] A_PRIO = {2'h0, vic_pkg::IDX_PRIO, 2'h0};
  localparam logic [11:0] A_MASK = {2'h0, vic_pkg::IDX_MASK, 2'h0};
  localparam logic [11:0] A_CTRL = {2'h0, vic_pkg::IDX_CTRL, 2'h0};
  localparam logic [11:0] A_PINS = {2'h0, vic_pkg::IDX_PINS, 2'h0};
  logic              clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [11:0]       adr = 12'h000;
  logic [31:0]       wdat = 32'h0, wb_dat_o;
  logic [2:0]        pin = 3'h0;
  logic [4:0]        ev = 5'h00;
  logic              wb_ack_o, save_stb_o, branch_stb_o, int_busy_o, pm_rd_o, irq_o;
  logic              ready, pm_valid;
  logic [15:0]       branch_addr_o, pm_addr_o;
  logic [7:0]        pm_data;
  vic_pkg::vic_ctx_t ctx, save_ctx_o;
  int                n_errors = 0, check_count = 0;
  vic_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .port3_bit1_pin_i(pin[0]), .port3_bit2_pin_i(pin[1]),
    .port3_bit3_pin_i(pin[2]), .comparator_input_one_i(ev[0]),
    .comparator_input_two_i(ev[1]), .timer16_evt_i(ev[2]), .timer8_evt_i(ev[3]),
    .lowvolt_evt_i(ev[4]), .core_ready_i(ready), .core_ctx_i(ctx), .save_ctx_o(save_ctx_o),
    .save_stb_o(save_stb_o), .branch_addr_o(branch_addr_o), .branch_stb_o(branch_stb_o),
    .int_busy_o(int_busy_o), .pm_addr_o(pm_addr_o), .pm_rd_o(pm_rd_o),
    .pm_data_i(pm_data), .pm_valid_i(pm_valid), .irq_o(irq_o));
  vic_far_model u_far (.clk_i(clk_i), .rst_i(rst_i), .busy_i(int_busy_o), .ctx_o(ctx),
    .ready_o(ready), .pm_addr_i(pm_addr_o), .pm_rd_i(pm_rd_o), .pm_data_o(pm_data),
    .pm_valid_o(pm_valid));
  always #2.5 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, 24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    if (n >= 20) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    end
    {cyc, stb} <= 2'h0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    logic [31:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(q, {24'h0, e});
  endtask
  task automatic pins(input logic [2:0] v);
    @(posedge clk_i);
    pin <= v;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic pulse(input logic [4:0] v);
    @(posedge clk_i);
    ev <= v;
    @(posedge clk_i);
    ev <= 5'h00;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic br(input logic [15:0] e);
    int n;
    n = 0;
    while (branch_stb_o !== 1'b1 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    chk({16'h0, branch_addr_o}, {16'h0, e});
  endtask
  task automatic t_regs();
    rd(A_REQ, 8'h00);
    rd(A_MASK, 8'h00);
    rd(A_PRIO, 8'h00);
    rd(A_CTRL, 8'h00);
    wr(12'h100, 8'hFF);
    rd(12'h100, 8'h00);
  endtask
  task automatic t_edges();
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      wr(A_REQ, {c, 6'h3F});
      pins(3'b011);
      rd(A_REQ, {c, 3'h0, c[1], 1'b0, c[0]});
      wr(A_REQ, {c, 6'h3F});
      pins(3'b000);
      rd(A_REQ, {c, 3'h0, c != 2'h2, 1'b0, c != 2'h1});
    end
  endtask
  task automatic t_line1();
    wr(A_REQ, 8'h3F);
    pins(3'b101);
    rd(A_REQ, 8'h00);
    rd(A_PINS, 8'h05);
    pins(3'b000);
    rd(A_REQ, 8'h06);
    rd(A_REQ, 8'h06);
    wr(A_REQ, 8'h02);
    rd(A_REQ, 8'h04);
    wr(A_REQ, 8'h3F);
    pulse(5'b00001);
    rd(A_REQ, 8'h04);
    wr(A_REQ, 8'h3F);
    pulse(5'b00010);
    rd(A_REQ, 8'h01);
  endtask
  task automatic t_poll();
    wr(A_REQ, 8'h3F);
    pulse(5'b00100);
    rd(A_REQ, 8'h08);
    chk(irq_o, 1'b0);
    wr(A_MASK, 8'h08);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b1);
    wr(A_MASK, 8'h00);
    wr(A_CTRL, 8'h01);
    repeat (4) @(posedge clk_i);
    chk(int_busy_o, 1'b0);
    rd(A_REQ, 8'h08);
  endtask
  task automatic t_grant();
    pulse(5'b01000);
    wr(A_PRIO, 8'h04);
    wr(A_MASK, 8'h3F);
    br(16'h3839);
    rd(A_CTRL, 8'h00);
    rd(A_REQ, 8'h08);
    wr(A_CTRL, 8'h01);
    br(16'h3637);
    rd(A_REQ, 8'h00);
    chk(irq_o, 1'b0);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_edges();
    t_line1();
    t_poll();
    t_grant();
    give_verdict();
  end
  initial begin
    #50000;
    n_errors++;
    $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    give_verdict();
  end
endmodule
`default_nettype wire
